// ===== shared/ptc_pkg.sv
`default_nettype none
package ptc_pkg;
  // register byte addresses (no offsets printed, so these are chosen)
  localparam logic [7:0] ADDR_TRIGGER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_OUTPUT_PIN_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_MODULE_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_FAULT_LIMIT_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h18;
  // reset values
  localparam logic [15:0] TRIGGER_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] OUTPUT_PIN_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] FAULT_LIMIT_CONTROL_RESET = 16'h0003;
  // trigger_control fields
  localparam int TRG_DIV_LSB = 12;
  localparam int TRG_MERGE_BIT = 7;
  localparam int TRG_START_LSB = 0;
  localparam logic [15:0] TRIGGER_CONTROL_WMASK = 16'hf0bf;
  // output_pin_control fields
  localparam int PIN_HIGH_OWN_BIT = 15;
  localparam int PIN_LOW_OWN_BIT = 14;
  localparam int PIN_HIGH_INV_BIT = 13;
  localparam int PIN_LOW_INV_BIT = 12;
  localparam int PIN_MODE_LSB = 10;
  localparam int PIN_HIGH_OVR_BIT = 9;
  localparam int PIN_LOW_OVR_BIT = 8;
  localparam int PIN_OVR_VAL_LSB = 6;
  localparam int PIN_FLT_VAL_LSB = 4;
  localparam int PIN_LIM_VAL_LSB = 2;
  localparam int PIN_SWAP_BIT = 1;
  localparam int PIN_OVR_SYNC_BIT = 0;
  // fault_limit_control fields
  localparam int FLC_BEHAVIOUR_LSB = 0;
  localparam int FLC_LIMIT_EN_BIT = 2;
  localparam int FLC_INDEP_BIT = 3;
  localparam logic [15:0] FAULT_LIMIT_CONTROL_WMASK = 16'h000f;
  // interrupt status bits
  localparam int IRQ_TRIGGER_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_LIMIT_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  typedef enum logic [1:0] {PTC_COMPLEMENTARY, PTC_REDUNDANT, PTC_PUSH_PULL, PTC_INDEPENDENT} ptc_pair_mode_t;
  typedef enum logic [1:0] {PTC_FLT_LATCHED, PTC_FLT_CYCLE, PTC_FLT_RESERVED, PTC_FLT_OFF} ptc_fault_mode_t;
endpackage : ptc_pkg
`default_nettype wire

// ===== logic/ptc_sync2.sv
`default_nettype none
// two-flop synchroniser for asynchronous pin inputs
module ptc_sync2 (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  // first stage feeds only the second
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // ptc_sync2
`default_nettype wire

// ===== logic/ptc_pin_stage.sv
`default_nettype none
// per-pin source priority, ownership and polarity
module ptc_pin_stage (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic own,
  input wire logic invert,
  input wire logic ovr_en,
  input wire logic ovr_val,
  input wire logic flt_take,
  input wire logic flt_val,
  input wire logic lim_take,
  input wire logic lim_val,
  input wire logic gen_val,
  output logic pin_out,
  output logic pin_oe
);
  logic level;
  // override beats fault beats limit beats generator
  // source priority chain
  assign level = ovr_en ? ovr_val : flt_take ? flt_val : lim_take ? lim_val : gen_val;
  // registered so the pin never glitches between sources
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_out <= level ^ invert;
      pin_oe <= own;
    end
  end
endmodule // ptc_pin_stage
`default_nettype wire

// ===== logic/ptc_top.sv
`default_nettype none
module ptc_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic gen_high,
  input wire logic gen_low,
  input wire logic period_start,
  input wire logic primary_event,
  input wire logic secondary_event,
  input wire logic fault_in,
  input wire logic limit_in,
  output logic primary_trigger,
  output logic secondary_trigger,
  output logic high_output_pin,
  output logic high_output_pin_oe,
  output logic low_output_pin,
  output logic low_output_pin_oe,
  output logic irq
);
  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic [15:0] trigger_control_q;
  logic [15:0] output_pin_control_q;
  logic [15:0] fault_limit_control_q;
  logic pwm_module_enable_q;
  logic [ptc_pkg::IRQ_WIDTH-1:0] irq_status_q;
  logic [ptc_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic wr_pending_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic fault_s;
  logic limit_s;
  logic fault_latched_q;
  wire logic bus_take;
  wire logic [31:0] rd_mux;
  wire logic wr_go;
  wire logic [31:0] wdata;

  // zero-wait slave: every transfer finishes in its data phase
  assign bus_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign wr_go = wr_pending_q;
  assign wdata = hwdata;

  // read mux, unmapped addresses read as zero
  assign rd_mux =
    (haddr[7:0] == ptc_pkg::ADDR_TRIGGER_CONTROL) ? {16'h0000, trigger_control_q} :
    (haddr[7:0] == ptc_pkg::ADDR_OUTPUT_PIN_CONTROL) ? {16'h0000, output_pin_control_q} :
    (haddr[7:0] == ptc_pkg::ADDR_MODULE_CONTROL) ? {31'h00000000, pwm_module_enable_q} :
    (haddr[7:0] == ptc_pkg::ADDR_FAULT_LIMIT_CONTROL) ? {16'h0000, fault_limit_control_q} :
    (haddr[7:0] == ptc_pkg::ADDR_IRQ_STATUS) ? {29'h00000000, irq_status_q} :
    (haddr[7:0] == ptc_pkg::ADDR_IRQ_MASK) ? {29'h00000000, irq_mask_q} :
    (haddr[7:0] == ptc_pkg::ADDR_PIN_STATUS) ?
      {26'h0000000, fault_latched_q, limit_s, high_output_pin_oe, high_output_pin,
       low_output_pin_oe, low_output_pin} :
    32'h00000000;

  // address phase capture; read data latched for the data phase
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pending_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wr_pending_q <= bus_take && hwrite;
      wr_addr_q <= haddr[7:0];
      if (bus_take && !hwrite)
        rdata_q <= rd_mux;
    end
  end

  wire logic wr_trg = wr_go && (wr_addr_q == ptc_pkg::ADDR_TRIGGER_CONTROL);
  wire logic wr_pin = wr_go && (wr_addr_q == ptc_pkg::ADDR_OUTPUT_PIN_CONTROL);
  wire logic wr_mod = wr_go && (wr_addr_q == ptc_pkg::ADDR_MODULE_CONTROL);
  wire logic wr_flc = wr_go && (wr_addr_q == ptc_pkg::ADDR_FAULT_LIMIT_CONTROL);
  wire logic wr_sts = wr_go && (wr_addr_q == ptc_pkg::ADDR_IRQ_STATUS);
  wire logic wr_msk = wr_go && (wr_addr_q == ptc_pkg::ADDR_IRQ_MASK);

  // control register writes; unimplemented bits stay zero
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trigger_control_q <= ptc_pkg::TRIGGER_CONTROL_RESET;
      output_pin_control_q <= ptc_pkg::OUTPUT_PIN_CONTROL_RESET;
      fault_limit_control_q <= ptc_pkg::FAULT_LIMIT_CONTROL_RESET;
      pwm_module_enable_q <= 1'b0;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr_trg)
        trigger_control_q <= wdata[15:0] & ptc_pkg::TRIGGER_CONTROL_WMASK;
      if (wr_pin)
        output_pin_control_q <= wdata[15:0];
      if (wr_flc)
        fault_limit_control_q <= wdata[15:0] & ptc_pkg::FAULT_LIMIT_CONTROL_WMASK;
      if (wr_mod)
        pwm_module_enable_q <= wdata[0];
      if (wr_msk)
        irq_mask_q <= wdata[ptc_pkg::IRQ_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire logic [3:0] trigger_divider = trigger_control_q[ptc_pkg::TRG_DIV_LSB +: 4];
  wire logic dual_trigger_merge = trigger_control_q[ptc_pkg::TRG_MERGE_BIT];
  wire logic [5:0] trigger_start_delay = trigger_control_q[ptc_pkg::TRG_START_LSB +: 6];
  wire logic high_pin_own = output_pin_control_q[ptc_pkg::PIN_HIGH_OWN_BIT];
  wire logic low_pin_own = output_pin_control_q[ptc_pkg::PIN_LOW_OWN_BIT];
  wire logic high_pin_invert = output_pin_control_q[ptc_pkg::PIN_HIGH_INV_BIT];
  wire logic low_pin_invert = output_pin_control_q[ptc_pkg::PIN_LOW_INV_BIT];
  wire logic [1:0] pair_output_mode = output_pin_control_q[ptc_pkg::PIN_MODE_LSB +: 2];
  wire logic high_override_en = output_pin_control_q[ptc_pkg::PIN_HIGH_OVR_BIT];
  wire logic low_override_en = output_pin_control_q[ptc_pkg::PIN_LOW_OVR_BIT];
  wire logic [1:0] override_value = output_pin_control_q[ptc_pkg::PIN_OVR_VAL_LSB +: 2];
  wire logic [1:0] fault_value = output_pin_control_q[ptc_pkg::PIN_FLT_VAL_LSB +: 2];
  wire logic [1:0] limit_value = output_pin_control_q[ptc_pkg::PIN_LIM_VAL_LSB +: 2];
  wire logic swap = output_pin_control_q[ptc_pkg::PIN_SWAP_BIT];
  wire logic override_sync = output_pin_control_q[ptc_pkg::PIN_OVR_SYNC_BIT];
  wire logic [1:0] fault_behaviour = fault_limit_control_q[ptc_pkg::FLC_BEHAVIOUR_LSB +: 2];
  wire logic limit_enable = fault_limit_control_q[ptc_pkg::FLC_LIMIT_EN_BIT];
  wire logic indep_fault = fault_limit_control_q[ptc_pkg::FLC_INDEP_BIT];

  // ---------------------------------------------------------------
  // pin inputs
  // ---------------------------------------------------------------
  ptc_sync2 u_sync_fault (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(fault_in),
    .sync_out(fault_s)
  );
  ptc_sync2 u_sync_limit (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(limit_in),
    .sync_out(limit_s)
  );

  // ---------------------------------------------------------------
  // trigger postscaler
  // ---------------------------------------------------------------
  logic enable_d1_q;
  logic [5:0] start_cnt_q;
  logic [3:0] div_cnt_q;
  logic primary_trigger_q;
  logic secondary_trigger_q;
  wire logic enable_rise = pwm_module_enable_q && !enable_d1_q;
  wire logic start_done = (start_cnt_q >= trigger_start_delay);
  wire logic merged_event = primary_event || (dual_trigger_merge && secondary_event);
  wire logic count_event = pwm_module_enable_q && start_done && merged_event;
  wire logic div_hit = count_event && (div_cnt_q == trigger_divider);

  // start delay counts PWM periods; divider counts qualified events
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_d1_q <= 1'b0;
      start_cnt_q <= 6'h00;
      div_cnt_q <= 4'h0;
      primary_trigger_q <= 1'b0;
      secondary_trigger_q <= 1'b0;
    end
    else
    begin
      enable_d1_q <= pwm_module_enable_q;
      if (enable_rise)
      begin
        start_cnt_q <= 6'h00;
        div_cnt_q <= 4'h0;
      end
      else
      begin
        // count PWM cycles before first trigger
        if (pwm_module_enable_q && period_start && !start_done)
          start_cnt_q <= start_cnt_q + 6'h01;
        if (count_event)
          div_cnt_q <= div_hit ? 4'h0 : div_cnt_q + 4'h1;
      end
      primary_trigger_q <= div_hit && !enable_rise;
      // separate secondary trigger when not merged
      secondary_trigger_q <= pwm_module_enable_q && start_done && !dual_trigger_merge &&
                             secondary_event && !enable_rise;
    end
  end
  assign primary_trigger = primary_trigger_q;
  assign secondary_trigger = secondary_trigger_q;

  // ---------------------------------------------------------------
  // fault and limit qualification
  // ---------------------------------------------------------------
  // fault behaviour selection
  wire logic fault_armed = (fault_behaviour == ptc_pkg::PTC_FLT_LATCHED) ||
                           (fault_behaviour == ptc_pkg::PTC_FLT_CYCLE);
  // latched mode holds until the input is gone and software releases it
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fault_latched_q <= 1'b0;
    else if (fault_armed && fault_s)
      fault_latched_q <= 1'b1;
    else if (!fault_armed || (fault_behaviour == ptc_pkg::PTC_FLT_CYCLE && period_start)
             || (wr_sts && wdata[ptc_pkg::IRQ_FAULT_BIT]))
      fault_latched_q <= 1'b0;
  end
  wire logic fault_active = fault_armed && (fault_s || fault_latched_q);
  wire logic limit_active = limit_enable && limit_s;

  wire logic high_flt_take = indep_fault ? limit_active : fault_active;
  wire logic low_flt_take = fault_active;
  wire logic high_lim_take = !indep_fault && limit_active;
  wire logic low_lim_take = !indep_fault && limit_active;

  // ---------------------------------------------------------------
  // override staging and pair mode
  // ---------------------------------------------------------------
  logic [3:0] ovr_applied_q;
  wire logic [3:0] ovr_request = {high_override_en, low_override_en, override_value};
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ovr_applied_q <= 4'h0;
    else if (!override_sync || period_start)
      ovr_applied_q <= ovr_request;
  end

  // pair mode assumed stable while enabled
  wire logic gen_low_mode =
    (pair_output_mode == ptc_pkg::PTC_COMPLEMENTARY) ? !gen_high :
    (pair_output_mode == ptc_pkg::PTC_REDUNDANT) ? gen_high :
    (pair_output_mode == ptc_pkg::PTC_PUSH_PULL) ? gen_low :
    gen_low;
  wire logic gen_high_en = pwm_module_enable_q && gen_high;
  wire logic gen_low_en = pwm_module_enable_q && gen_low_mode;
  wire logic high_src = swap ? gen_low_en : gen_high_en;
  wire logic low_src = swap ? gen_high_en : gen_low_en;

  ptc_pin_stage u_high (
    .clock(clock),
    .reset_n(reset_n),
    .own(high_pin_own),
    .invert(high_pin_invert),
    .ovr_en(ovr_applied_q[3]),
    .ovr_val(ovr_applied_q[1]),
    .flt_take(high_flt_take),
    .flt_val(fault_value[1]),
    .lim_take(high_lim_take),
    .lim_val(limit_value[1]),
    .gen_val(high_src),
    .pin_out(high_output_pin),
    .pin_oe(high_output_pin_oe)
  );
  ptc_pin_stage u_low (
    .clock(clock),
    .reset_n(reset_n),
    .own(low_pin_own),
    .invert(low_pin_invert),
    .ovr_en(ovr_applied_q[2]),
    .ovr_val(ovr_applied_q[0]),
    .flt_take(low_flt_take),
    .flt_val(fault_value[0]),
    .lim_take(low_lim_take),
    .lim_val(limit_value[0]),
    .gen_val(low_src),
    .pin_out(low_output_pin),
    .pin_oe(low_output_pin_oe)
  );

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  // only primary path raises trigger interrupt
  wire logic [ptc_pkg::IRQ_WIDTH-1:0] irq_events = {limit_active, fault_active, primary_trigger_q};
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      irq_status_q <= '0;
    else
      irq_status_q <= (irq_status_q & ~(wr_sts ? wdata[ptc_pkg::IRQ_WIDTH-1:0] : '0)) | irq_events;
  end
  assign irq = |(irq_status_q & irq_mask_q);
endmodule // ptc_top
`default_nettype wire

// ===== bench/ptc_properties.sv
`default_nettype none
// ----
// port checks
// ----
module ptc_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic primary_event,
  input wire logic secondary_event,
  input wire logic primary_trigger,
  input wire logic secondary_trigger,
  input wire logic high_output_pin_oe,
  input wire logic low_output_pin_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // pin control write address phase
  sequence s_wr_pin;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == ptc_pkg::ADDR_OUTPUT_PIN_CONTROL;
  endsequence
  // flags a pin control write in its data phase
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wr_q <= 1'b0;
    else
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == ptc_pkg::ADDR_OUTPUT_PIN_CONTROL;
  end
  a_ready_always:
    assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay:
    assert property (!hresp) else $error("hresp not okay");
  a_upper_zero:
    assert property (hrdata[31:16] == 16'h0000) else $error("upper read data set");
  a_prim_cause:
    assert property (primary_trigger |-> $past(primary_event) || $past(secondary_event))
    else $error("primary trigger without event");
  a_sec_cause:
    assert property (secondary_trigger |-> $past(secondary_event)) else $error("secondary trigger without event");
  a_own_high:
    assert property ($changed(high_output_pin_oe) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("high enable moved without write");
  a_own_low:
    assert property ($changed(low_output_pin_oe) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("low enable moved without write");
  a_irq_quiet:
    assert property ($past(reset_n) == 1'b0 |-> !irq) else $error("irq high after reset");
  // write lands one edge after the address phase, the pin one edge later, seen one edge after that
  c_pin_write: cover property (s_wr_pin ##3 $changed(high_output_pin_oe));
endmodule // ptc_properties

bind ptc_top ptc_properties u_ptc_properties (
  .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .primary_event(primary_event),
  .secondary_event(secondary_event), .primary_trigger(primary_trigger), .secondary_trigger(secondary_trigger),
  .high_output_pin_oe(high_output_pin_oe), .low_output_pin_oe(low_output_pin_oe), .irq(irq)
);
`default_nettype wire

// ===== bench/ptc_gate_model.sv
`default_nettype none
// ----
// gate drivers and converter trigger input
// ----
module ptc_gate_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic primary_trigger,
  input wire logic secondary_trigger,
  input wire logic high_output_pin,
  input wire logic high_output_pin_oe,
  input wire logic low_output_pin,
  input wire logic low_output_pin_oe,
  output logic [7:0] prim_count,
  output logic [7:0] sec_count,
  output logic high_level,
  output logic low_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // driver inputs have pull-downs, so a released pin reads low
  assign high_level = high_output_pin_oe ? high_output_pin : 1'b0;
  assign low_level = low_output_pin_oe ? low_output_pin : 1'b0;
  // converter counts every pulse; bench compares differences
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      {prim_count, sec_count} <= 16'h0000;
    else
      {prim_count, sec_count} <= {prim_count + 8'(primary_trigger), sec_count + 8'(secondary_trigger)};
  end
endmodule // ptc_gate_model
`default_nettype wire

// ===== bench/pwm_trigger_and_pin_control_tb_top.sv
`default_nettype none
module pwm_trigger_and_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, hsel, hwrite, gen_high, gen_low, period_start, primary_event, secondary_event;
  logic fault_in, limit_in, hreadyout, hresp, primary_trigger, secondary_trigger, irq, high_level, low_level;
  logic high_output_pin, high_output_pin_oe, low_output_pin, low_output_pin_oe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] prim_count, sec_count, p0, s0;
  int bad_count, n_tests, cyc;
  ptc_top u_ptc_top (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gen_high(gen_high), .gen_low(gen_low),
    .period_start(period_start), .primary_event(primary_event), .secondary_event(secondary_event),
    .fault_in(fault_in), .limit_in(limit_in), .primary_trigger(primary_trigger),
    .secondary_trigger(secondary_trigger), .high_output_pin(high_output_pin),
    .high_output_pin_oe(high_output_pin_oe), .low_output_pin(low_output_pin),
    .low_output_pin_oe(low_output_pin_oe), .irq(irq));
  ptc_gate_model u_ptc_gate_model (.clock(clock), .reset_n(reset_n), .primary_trigger(primary_trigger),
    .secondary_trigger(secondary_trigger), .high_output_pin(high_output_pin),
    .high_output_pin_oe(high_output_pin_oe), .low_output_pin(low_output_pin),
    .low_output_pin_oe(low_output_pin_oe), .prim_count(prim_count), .sec_count(sec_count),
    .high_level(high_level), .low_level(low_level));
  // ----
  // clock and hang guard
  // ----
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // whole run is a few hundred cycles; the ceiling leaves ample slack
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clock);
      cyc++;
      if (cyc == 5000)
      begin
        bad_count++;
        results();
      end
    end
  end
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single-word transfer; the address phase is held until hready
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  // expected order: high enable, low enable, high level, low level
  // three edges: override staging adds one register ahead of the pin flop
  task pins(input logic [3:0] e);
    repeat (3) @(posedge clock);
    check("pins", {28'h0, high_output_pin_oe, low_output_pin_oe, high_level, low_level}, {28'h0, e});
  endtask
  // order: period start, primary event, secondary event
  task pulse(input logic [2:0] w);
    {period_start, primary_event, secondary_event} <= w;
    @(posedge clock);
    {period_start, primary_event, secondary_event} <= 3'b000;
    @(posedge clock);
  endtask
  task counts(input logic [7:0] ep, input logic [7:0] es);
    repeat (2) @(posedge clock);
    check("primary", {24'h0, prim_count - p0}, {24'h0, ep});
    check("secondary", {24'h0, sec_count - s0}, {24'h0, es});
    p0 = prim_count;
    s0 = sec_count;
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    {hsel, hwrite, gen_high, gen_low, period_start, primary_event, secondary_event, fault_in, limit_in} = '0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    {p0, s0, reset_n} = 17'h0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rchk("trg reset", 8'h00, 32'h0);
    rchk("pin reset", 8'h04, 32'h0);
    rchk("flc reset", 8'h0c, 32'h3);
    ahb(1'b1, 8'h1c, 32'hffff_ffff);
    rchk("unmapped", 8'h1c, 32'h0);
    ahb(1'b1, 8'h00, 32'hffff_ffff);
    rchk("trg bits", 8'h00, 32'h0000_f0bf);
    ahb(1'b1, 8'h04, 32'hffff_ffff);
    rchk("pin bits", 8'h04, 32'h0000_ffff);
    gen_high <= 1'b1;
    // pair mode only changed while disabled; generator reaches pins only when enabled
    for (int i = 3; i >= 0; i--)
    begin
      ahb(1'b1, 8'h08, 32'h0);
      ahb(1'b1, 8'h04, {16'h0, 4'hc, i[1:0], 10'h0});
      ahb(1'b1, 8'h08, 32'h1);
      pins(i == 1 ? 4'hf : 4'he);
    end
    ahb(1'b1, 8'h04, 32'h0000_f000);
    pins(4'hd);
    ahb(1'b1, 8'h04, 32'h0000_c002);
    pins(4'hd);
    ahb(1'b1, 8'h04, 32'h0000_c340);
    pins(4'hd);
    ahb(1'b1, 8'h04, 32'h0000_c381);
    pins(4'hd);
    pulse(3'b100);
    pins(4'he);
    // cycle fault, then override above it
    ahb(1'b1, 8'h0c, 32'h1);
    ahb(1'b1, 8'h04, 32'h0000_c010);
    fault_in <= 1'b1;
    repeat (2) @(posedge clock);
    pins(4'hd);
    ahb(1'b1, 8'h04, 32'h0000_c3d0);
    pins(4'hf);
    fault_in <= 1'b0;
    ahb(1'b1, 8'h04, 32'h0000_c010);
    pulse(3'b100);
    pins(4'he);
    // latched fault holds past the period start until cleared
    ahb(1'b1, 8'h0c, 32'h0);
    fault_in <= 1'b1;
    repeat (2) @(posedge clock);
    pins(4'hd);
    fault_in <= 1'b0;
    pulse(3'b100);
    pins(4'hd);
    ahb(1'b1, 8'h10, 32'h2);
    pins(4'he);
    // fault input off, current limit normal then independent
    ahb(1'b1, 8'h0c, 32'h7);
    ahb(1'b1, 8'h04, 32'h0000_c00c);
    {fault_in, limit_in} <= 2'b11;
    repeat (2) @(posedge clock);
    pins(4'hf);
    rchk("pin status", 8'h18, 32'h1f);
    ahb(1'b1, 8'h0c, 32'hf);
    pins(4'hc);
    {fault_in, limit_in} <= 2'b00;
    // triggers: divide by 3, one period of start delay
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b1, 8'h00, 32'h0000_2001);
    ahb(1'b1, 8'h10, 32'h7);
    ahb(1'b1, 8'h14, 32'h1);
    ahb(1'b1, 8'h08, 32'h1);
    // the enable-rise cycle refuses events, so let it pass first
    @(posedge clock);
    pulse(3'b010);
    counts(8'd0, 8'd0);
    pulse(3'b100);
    repeat (6) pulse(3'b010);
    counts(8'd2, 8'd0);
    check("irq", {31'h0, irq}, 32'h1);
    rchk("status", 8'h10, 32'h1);
    ahb(1'b1, 8'h10, 32'h1);
    repeat (2) pulse(3'b001);
    counts(8'd0, 8'd2);
    check("irq", {31'h0, irq}, 32'h0);
    rchk("status", 8'h10, 32'h0);
    pulse(3'b010);
    // re-enable merged with no delay: the partial count must be gone
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b1, 8'h00, 32'h0000_2080);
    ahb(1'b1, 8'h08, 32'h1);
    @(posedge clock);
    pulse(3'b010);
    pulse(3'b001);
    counts(8'd0, 8'd0);
    pulse(3'b010);
    counts(8'd1, 8'd0);
    results();
  end
endmodule // pwm_trigger_and_pin_control_tb_top
`default_nettype wire
